// File: design/motor_stop_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module motor_stop_mode_control (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_stop_cmd,
    input wire logic [1:0] i_stop_type,
    input wire logic [3:0] i_quick_src,
    input wire logic [1:0] i_access_level,
    input wire logic [5:0] i_logic_in,
    input wire logic [15:0] i_net_ctrl,
    input wire logic i_wire_control_sel,
    input wire logic [1:0] i_two_wire_type,
    input wire logic i_div_wr,
    input wire logic [3:0] i_div_wdata,
    input wire logic [15:0] i_target_speed,
    input wire logic [15:0] i_ramp_step,
    output logic [15:0] o_speed,
    output logic o_drive_en,
    output logic o_dc_brake,
    output logic o_quick_active,
    output logic [3:0] o_ramp_divider,
    output logic o_div_access
);
    typedef enum logic [2:0] {
        RUNNING, IDLE, RAMP_DOWN, COASTING, DC_BRAKING
    } state_t;
    state_t state_q;
    logic [1:0] stop_type_q; // Latched stop type
    logic [3:0] src_q; // Validated quick stop source
    logic [3:0] div_q; // Ramp divider setting
    logic [15:0] speed_q; // Present output speed
    logic [4:0] net_prev_q; // Previous net bits for edge detect
    logic quick_q; // Quick stop latched
    logic run_prev_q; // For fresh run command detection
    logic run_block_q; // Waits for a fresh run command
    logic [15:0] step; // Scaled ramp step
    logic trig; // Quick stop trigger event
    logic trig_level; // Trigger still held
    logic auto_restart; // Restart allowed on trigger release
    logic stop_req; // Stop request from run drop, stop command or restart block
    logic quick_ramp; // Divider applies to the next ramp step

    // Decode whether a source code is acceptable at given access level
    function automatic logic src_ok(input logic [3:0] s,
                                    input logic [1:0] lvl);
        if (s <= stop_mode_pkg::SRC_LI_LAST) begin
            src_ok = 1'b1;
        end else if (s <= stop_mode_pkg::SRC_NET_LAST) begin
            src_ok = (lvl == stop_mode_pkg::ACCESS_LEVEL_THREE);
        end else begin
            src_ok = 1'b0;
        end
    endfunction

    // Illegal sources fall back to unassigned, so nothing fires
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            src_q <= stop_mode_pkg::SRC_NONE;
        end else if (src_ok(i_quick_src, i_access_level)) begin
            src_q <= i_quick_src;
        end else begin
            src_q <= stop_mode_pkg::SRC_NONE;
        end
    end

    // Divider writes honoured only when meaningful and in range
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            div_q <= stop_mode_pkg::DIV_RST;
        end else if (i_div_wr && o_div_access &&
                     i_div_wdata <= stop_mode_pkg::DIV_MAX) begin
            div_q <= i_div_wdata;
        end
    end

    // Access flag for the divider setting
    always_comb begin
        o_div_access = (i_stop_type == stop_mode_pkg::QUICK_STOP) &&
                       (src_q != stop_mode_pkg::SRC_NONE);
    end

    // Trigger: logic input low level, network bit rising edge
    always_comb begin
        trig = 1'b0;
        trig_level = 1'b0;
        if (src_q >= stop_mode_pkg::SRC_LI_FIRST &&
            src_q <= stop_mode_pkg::SRC_LI_LAST) begin
            trig_level = !i_logic_in[3'(src_q - stop_mode_pkg::SRC_LI_FIRST)];
            trig = trig_level;
        end else if (src_q >= stop_mode_pkg::SRC_NET_FIRST) begin
            trig_level = i_net_ctrl[stop_mode_pkg::NET_BIT_LO +
                int'(src_q - stop_mode_pkg::SRC_NET_FIRST)];
            trig = trig_level && !net_prev_q[
                3'(src_q - stop_mode_pkg::SRC_NET_FIRST)];
        end
    end

    // Remember network bits for edge detection
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            net_prev_q <= '0;
        end else begin
            net_prev_q <= i_net_ctrl[stop_mode_pkg::NET_BIT_HI:
                                     stop_mode_pkg::NET_BIT_LO];
        end
    end

    always_comb begin
        auto_restart = (i_wire_control_sel == stop_mode_pkg::TWO_WIRE_CTRL)
            && (i_two_wire_type == stop_mode_pkg::LEVEL_TYPE ||
                i_two_wire_type == stop_mode_pkg::FORWARD_PRIORITY_TYPE);
        stop_req = !i_run || i_stop_cmd || run_block_q;
    end

    // Quick stop latch; it clears once the trigger is released and the state is not RAMP_DOWN
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            quick_q <= 1'b0;
        end else if (trig) begin
            quick_q <= 1'b1;
        end else if (!trig_level && state_q != RAMP_DOWN) begin
            quick_q <= 1'b0;
        end
    end

    // Block restart after quick stop unless two-wire level or forward priority control
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            run_prev_q <= 1'b0;
            run_block_q <= 1'b0;
        end else begin
            run_prev_q <= i_run;
            if (trig && !auto_restart) begin
                run_block_q <= 1'b1;
            end else if (i_run && !run_prev_q) begin
                run_block_q <= 1'b0;
            end
        end
    end

    // Stop sequencing
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_q <= IDLE;
            stop_type_q <= stop_mode_pkg::STOP_TYPE_RST;
        end else begin
            unique case (state_q)
                RUNNING: begin
                    if (trig || quick_q) begin
                        stop_type_q <= stop_mode_pkg::QUICK_STOP;
                        state_q <= RAMP_DOWN;
                    end else if (stop_req) begin
                        stop_type_q <= i_stop_type;
                        unique case (i_stop_type)
                            stop_mode_pkg::COAST_STOP:
                                state_q <= COASTING;
                            stop_mode_pkg::DC_BRAKE_STOP:
                                state_q <= DC_BRAKING;
                            default: state_q <= RAMP_DOWN;
                        endcase
                    end
                end
                RAMP_DOWN: begin
                    if (speed_q == stop_mode_pkg::SPD_ZERO) begin
                        state_q <= IDLE;
                    end
                end
                COASTING, DC_BRAKING, IDLE: begin
                    // Restart needs run, no trigger held, no block
                    if (!stop_req && !quick_q && !trig_level) begin
                        state_q <= RUNNING;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    // Speed follows target while running, ramps down in RAMP_DOWN, is zero otherwise
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            speed_q <= stop_mode_pkg::SPD_ZERO;
        end else if (state_q == RUNNING) begin
            speed_q <= i_target_speed;
        end else if (state_q == RAMP_DOWN) begin
            speed_q <= (speed_q > step) ? speed_q - step
                                        : stop_mode_pkg::SPD_ZERO;
        end else begin
            speed_q <= stop_mode_pkg::SPD_ZERO;
        end
    end

    // Quick ramp selection looks at the stop being entered, so the
    // scaled step is already registered for the first ramp cycle
    always_comb begin
        quick_ramp = (state_q == RAMP_DOWN) &&
                     (stop_type_q == stop_mode_pkg::QUICK_STOP);
        if (state_q == RUNNING) begin
            quick_ramp = trig || quick_q || (stop_req &&
                (i_stop_type == stop_mode_pkg::QUICK_STOP));
        end
    end

    // Step scaler; only the quick stop uses the divider
    ramp_step_scale u_scale (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_quick(quick_ramp),
        .i_div(div_q),
        .i_step(i_ramp_step),
        .o_step(step)
    );

    // Registered-derived outputs
    always_comb begin
        o_speed = speed_q;
        o_drive_en = (state_q == RUNNING) || (state_q == RAMP_DOWN) ||
                     (state_q == DC_BRAKING);
        o_dc_brake = (state_q == DC_BRAKING);
        o_quick_active = quick_q;
        o_ramp_divider = div_q;
    end
endmodule
`default_nettype wire

// File: design/stop_mode_pkg.sv
package stop_mode_pkg;
    // Stop type selection codes
    localparam logic [1:0] STOP_ON_RAMP = 2'h0;
    localparam logic [1:0] QUICK_STOP = 2'h1;
    localparam logic [1:0] COAST_STOP = 2'h2;
    localparam logic [1:0] DC_BRAKE_STOP = 2'h3;
    localparam logic [1:0] STOP_TYPE_RST = STOP_ON_RAMP;
    // Quick stop source codes: 0 none, 1..6 logic inputs, 7..11 net bits
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_LI_FIRST = 4'h1;
    localparam logic [3:0] SRC_LI_LAST = 4'h6;
    localparam logic [3:0] SRC_NET_FIRST = 4'h7;
    localparam logic [3:0] SRC_NET_LAST = 4'hb;
    // Network control word bit index of first assignable bit
    localparam int NET_BIT_LO = 11;
    localparam int NET_BIT_HI = 15;
    // Access level code meaning level three
    localparam logic [1:0] ACCESS_LEVEL_THREE = 2'h3;
    // Ramp divider range and factory value
    localparam logic [3:0] DIV_MAX = 4'ha;
    localparam logic [3:0] DIV_RST = 4'h4;
    // Wire control / two wire type codes
    localparam logic TWO_WIRE_CTRL = 1'b0;
    localparam logic [1:0] LEVEL_TYPE = 2'h0;
    localparam logic [1:0] FORWARD_PRIORITY_TYPE = 2'h2;
    // Speed width and minimum ramp step
    localparam int SPD_W = 16;
    localparam logic [15:0] SPD_ZERO = 16'h0000;
    localparam logic [15:0] MIN_RAMP_STEP = 16'hffff;
endpackage

// File: design/ramp_step_scale.sv
`timescale 1ns/1ps
`default_nettype none
// Registered deceleration step for the active stop ramp
module ramp_step_scale (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_quick,
    input wire logic [3:0] i_div,
    input wire logic [15:0] i_step,
    output logic [15:0] o_step
);
    // Step grows by the divider, saturating; 0 gives the steepest ramp
    logic [19:0] prod;
    always_comb begin
        prod = 20'(i_step) * 20'(i_div);
    end
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_step <= stop_mode_pkg::SPD_ZERO;
        end else if (!i_quick) begin
            o_step <= i_step;
        end else if (i_div == 4'h0) begin
            o_step <= stop_mode_pkg::MIN_RAMP_STEP;
        end else if (prod[19:16] != 4'h0) begin
            o_step <= stop_mode_pkg::MIN_RAMP_STEP;
        end else begin
            o_step <= prod[15:0];
        end
    end
endmodule
`default_nettype wire

// File: verif/stop_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Operator terminal inputs and network master facing the drive
module stop_source_model (
    input wire logic i_clk,
    input wire logic [5:0] i_li_low,
    input wire logic [4:0] i_net_set,
    output logic [5:0] o_logic_in,
    output logic [15:0] o_net_ctrl
);
    // Unassigned word bits keep moving so the drive must ignore them
    logic [10:0] spare_q = 11'h000;
    // Inputs idle high; pulling one low asks for a quick stop
    always_ff @(posedge i_clk) begin
        o_logic_in <= ~i_li_low;
        o_net_ctrl <= {i_net_set, spare_q};
        spare_q <= spare_q + 11'h001;
    end
endmodule
`default_nettype wire

// File: verif/motor_stop_mode_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Pin level checks of the stop controller
module motor_stop_mode_control_checker (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_stop_cmd,
    input wire logic [1:0] i_stop_type,
    input wire logic [3:0] i_quick_src,
    input wire logic [1:0] i_access_level,
    input wire logic [5:0] i_logic_in,
    input wire logic i_div_wr,
    input wire logic [3:0] i_div_wdata,
    input wire logic [15:0] o_speed,
    input wire logic o_drive_en,
    input wire logic o_dc_brake,
    input wire logic o_quick_active,
    input wire logic [3:0] o_ramp_divider,
    input wire logic o_div_access
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Drive stopping on command, no quick stop latched
    logic cmd_stop;
    assign cmd_stop = o_drive_en && !o_quick_active && (!i_run || i_stop_cmd);
    // Accepted divider write
    logic div_ok;
    assign div_ok = i_div_wr && o_div_access && i_div_wdata <= 4'ha;
    chk_div_range: assert property (o_ramp_divider <= 4'ha)
        else $error("divider out of range");
    chk_div_write: assert property (div_ok |=>
        o_ramp_divider == $past(i_div_wdata))
        else $error("divider not written");
    chk_div_hold: assert property (!div_ok |=> $stable(o_ramp_divider))
        else $error("divider changed without access");
    chk_div_access: assert property ($past(i_nrst)
        && $stable(i_stop_type) && $stable(i_quick_src)
        && $stable(i_access_level)
        && (i_quick_src <= 4'h6 || i_access_level != 2'h3)
        |-> o_div_access == (i_stop_type == 2'h1
        && i_quick_src inside {[4'h1:4'h6]}))
        else $error("divider access wrong");
    chk_coast_stop: assert property (cmd_stop && i_stop_type == 2'h2
        && $stable(i_stop_type) |-> ##[0:3] !o_drive_en)
        else $error("coast stop kept drive on");
    chk_dc_engage: assert property (cmd_stop && i_stop_type == 2'h3
        && $stable(i_stop_type) |-> ##[0:3] o_dc_brake)
        else $error("dc brake not applied");
    chk_min_ramp: assert property (o_quick_active
        && o_ramp_divider == 4'h0 |-> ##[0:3] o_speed == 16'h0000)
        else $error("divider zero too slow");
    chk_li_trigger: assert property ($past(i_nrst) && i_run
        && !i_stop_cmd && o_drive_en && !o_quick_active
        && i_quick_src == 4'h1
        && $stable(i_quick_src) && !i_logic_in[0] |-> ##[0:3] o_quick_active)
        else $error("low input did not trigger");
endmodule
bind motor_stop_mode_control motor_stop_mode_control_checker u_chk (
    .i_clk, .i_nrst, .i_run, .i_stop_cmd, .i_stop_type, .i_quick_src,
    .i_access_level, .i_logic_in, .i_div_wr, .i_div_wdata, .o_speed,
    .o_drive_en, .o_dc_brake, .o_quick_active, .o_ramp_divider, .o_div_access
);
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Stop cases from a table, then reset, divider and restart cases
module testbench;
    typedef struct packed {logic [1:0] st; logic [3:0] src; logic [1:0] lvl;
        logic [1:0] how; logic [4:0] lo; logic [4:0] hi; logic dc;} row_t;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_run = 1'b0, i_stop_cmd = 1'b0;
    logic i_wire_control_sel = 1'b0, i_div_wr = 1'b0, o_drive_en, o_dc_brake;
    logic o_quick_active, o_div_access;
    logic [1:0] i_stop_type = 2'h0, i_access_level = 2'h0;
    logic [1:0] i_two_wire_type = 2'h0;
    logic [3:0] i_quick_src = 4'h0, i_div_wdata = 4'h0, o_ramp_divider;
    // Gentle normal ramp: 16 steps, 4 steps at divider 4
    logic [15:0] i_target_speed = 16'h0100, i_ramp_step = 16'h0010;
    logic [15:0] i_net_ctrl, o_speed;
    logic [5:0] i_logic_in, li_low = 6'h00;
    logic [4:0] net_set = 5'h00;
    logic [3:0] rs [4] = '{4'h1, 4'h5, 4'h8, 4'h2};
    int num_errors = 0, compares = 0, n;
    // how: 0 run drop, 1 stop command, 2 source; hi of zero means refused
    row_t rows [14] = '{'{2'h0, 4'h0, 2'h0, 2'h0, 5'h0f, 5'h18, 1'b0},
        '{2'h0, 4'h0, 2'h0, 2'h1, 5'h0f, 5'h18, 1'b0},
        '{2'h1, 4'h0, 2'h0, 2'h0, 5'h03, 5'h0a, 1'b0},
        '{2'h2, 4'h0, 2'h0, 2'h1, 5'h01, 5'h03, 1'b0},
        '{2'h3, 4'h0, 2'h0, 2'h0, 5'h01, 5'h03, 1'b1},
        '{2'h0, 4'h1, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h2, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h3, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h4, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h5, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h6, 2'h0, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h7, 2'h3, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'hb, 2'h3, 2'h2, 5'h03, 5'h0a, 1'b0},
        '{2'h0, 4'h9, 2'h2, 2'h2, 5'h00, 5'h00, 1'b0}};
    always #2 i_clk = ~i_clk;
    stop_source_model u_stop_source_model (.i_clk, .i_li_low(li_low),
        .i_net_set(net_set), .o_logic_in(i_logic_in), .o_net_ctrl(i_net_ctrl));
    motor_stop_mode_control u_motor_stop_mode_control (.i_clk, .i_nrst,
        .i_run, .i_stop_cmd, .i_stop_type, .i_quick_src, .i_access_level,
        .i_logic_in, .i_net_ctrl, .i_wire_control_sel, .i_two_wire_type,
        .i_div_wr, .i_div_wdata, .i_target_speed, .i_ramp_step, .o_speed,
        .o_drive_en, .o_dc_brake, .o_quick_active, .o_ramp_divider,
        .o_div_access);
    task automatic err(input string msg);
        num_errors++;
        $display("ERROR %0t: %s", $time, msg);
    endtask
    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Inputs move one nanosecond after the edge
    task automatic tick(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask
    task automatic reset_dut(input int c);
        i_nrst = 1'b0;
        i_run = 1'b0;
        i_stop_cmd = 1'b0;
        li_low = 6'h00;
        net_set = 5'h00;
        tick(c);
        i_nrst = 1'b1;
    endtask
    // Bounded waits: a hang ends the run with a mismatch
    task automatic start_run();
        i_run = 1'b1;
        for (n = 0; o_speed !== i_target_speed && n < 20; n++) tick(1);
        if (n == 20) err("run timeout");
        if (n == 20) final_report();
    endtask
    task automatic wait_stop();
        for (n = 0; o_drive_en === 1'b1 && o_dc_brake !== 1'b1 && n < 40; n++)
            tick(1);
        if (n == 40) err("stop timeout");
        if (n == 40) final_report();
    endtask
    task automatic div_write(input logic [3:0] v, input logic a,
        input logic [3:0] d);
        i_div_wdata = v;
        i_div_wr = 1'b1;
        tick(1);
        i_div_wr = 1'b0;
        tick(1);
        compares++;
        if (o_div_access !== a || o_ramp_divider !== d) err("divider write");
    endtask
    task automatic run_row(input row_t r);
        reset_dut(2);
        i_stop_type = r.st;
        i_quick_src = r.src;
        i_access_level = r.lvl;
        start_run();
        if (r.how == 2'h0) i_run = 1'b0;
        else if (r.how == 2'h1) i_stop_cmd = 1'b1;
        else if (r.src <= 4'h6) li_low = 6'(6'h01 << (r.src - 4'h1));
        else net_set = 5'(5'h01 << (r.src - 4'h7));
        if (r.hi == 5'h00) begin
            tick(20);
            compares++;
            if (o_drive_en !== 1'b1) err("refused source stopped");
        end else begin
            wait_stop();
            compares += 2;
            if (n < r.lo || n > r.hi) err("stop timing");
            if (o_dc_brake !== r.dc) err("dc brake state");
        end
    endtask
    initial begin
        reset_dut(10);
        foreach (rows[k]) run_row(rows[k]);
        // Reset in mid-run must drop the drive
        start_run();
        reset_dut(10);
        compares += 2;
        if (o_ramp_divider !== 4'h4 || o_speed !== 16'h0000)
            err("reset values");
        if (o_drive_en !== 1'b0 || o_quick_active !== 1'b0)
            err("reset kept drive");
        i_quick_src = 4'h1;
        tick(2);
        div_write(4'h2, 1'b0, 4'h4);
        i_stop_type = 2'h1;
        i_quick_src = 4'h0;
        tick(2);
        div_write(4'h2, 1'b0, 4'h4);
        i_quick_src = 4'h1;
        tick(2);
        div_write(4'hb, 1'b1, 4'h4);
        div_write(4'ha, 1'b1, 4'ha);
        div_write(4'h0, 1'b1, 4'h0);
        start_run();
        li_low = 6'h01;
        wait_stop();
        compares++;
        if (n > 4) err("minimum ramp too slow");
        // Release of the input restarts only for two-wire level or priority
        foreach (rs[k]) begin
            reset_dut(2);
            i_quick_src = 4'h1;
            i_wire_control_sel = rs[k][3];
            i_two_wire_type = rs[k][2:1];
            start_run();
            li_low = 6'h01;
            wait_stop();
            li_low = 6'h00;
            tick(8);
            compares++;
            if (o_drive_en !== rs[k][0]) err("restart");
        end
        i_run = 1'b0;
        tick(2);
        start_run();
        compares++;
        if (o_drive_en !== 1'b1) err("fresh run refused");
        final_report();
    end
endmodule
`default_nettype wire
